// file: core/flight_ctrl.sv
`timescale 1ns/1ps
// Function
// [R01] Integer result counts whole 4MHz periods, saturating at 7FFF; the code counts 4-cycle periods of the 10 MHz clock.
// [R02] Fraction result is 16-bit part of one 4MHz period, max FFFF.
// [R03] Difference is signed up minus down across integer and fraction words.
// [R04] Echo mode biases the launching pins for reception.
// [R05] Echo mode only when its enable bit is set.
// [R06] Echo results go to the same registers as the executed command.
// [R07] Early-edge thresholds apply to up, down and difference commands.
// [R08] First threshold magnitude up to 127 LSB, sign from trigger edge.
// [R09] Separate 7-bit first thresholds for upstream and downstream.
// [R10] Measure first pulse width t1, then switch to return threshold.
// [R11] Separate 8-bit signed return thresholds per direction.
// [R12] Measure t2 width on the wave chosen by a 6-bit index.
// [R13] Store t1/t2 and t2/ideal ratios, ideal is half launch period.
// [R14] Failed measurement loads FFFF into its result registers.
// [R15] Failed difference loads 7FFF integer and FFFF fraction.
// [R16] Failed measurements stay out of the difference running average; the code still averages a down hit landing in the timeout cycle.
// [R17] Timeout over selected limit sets flag and interrupt when enabled.
// [R18] Boost on before a flight command, off when launch pulses end.
// [R19] Boost switching rate one of four steps by 2-bit field.
// [R20] Boost target voltage from 4-bit select field.
// [R21] Startup current limit below target, run limit after power good.
// [R22] Wait 4-bit settle delay in normal mode before launching.
// [R23] Interrupt stays asserted until status read.
// [R24] Launch start is time zero.
module flight_ctrl #(
	parameter int TIMEOUT_UNIT = flight_ctrl_pkg::TIMEOUT_BASE_CYC,
	parameter int SETTLE_UNIT  = flight_ctrl_pkg::SETTLE_UNIT_CYC
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        cmd_valid,
	input  wire logic [1:0]  cmd_code,
	input  wire logic        single_transducer_echo_enable,
	input  wire logic        stop_falling,
	input  wire logic [6:0]  upstream_first_threshold,
	input  wire logic [6:0]  downstream_first_threshold,
	input  wire logic [7:0]  upstream_return_threshold,
	input  wire logic [7:0]  downstream_return_threshold,
	input  wire logic [5:0]  second_wave_index,
	input  wire logic [2:0]  measure_timeout_select,
	input  wire logic [1:0]  boost_switch_rate,
	input  wire logic [3:0]  boost_voltage_select,
	input  wire logic [3:0]  startup_current_limit,
	input  wire logic [3:0]  run_current_limit,
	input  wire logic [3:0]  boost_settle_delay,
	input  wire logic [7:0]  launch_half_period,
	input  wire logic        int_enable,
	input  wire logic        status_read,
	input  wire logic        boost_power_good,
	input  wire logic        launch_done,
	input  wire logic        comp_in,
	input  wire logic        stop_hit,
	input  wire logic [15:0] hit_fraction,
	output logic             busy,
	output logic             boost_enable,
	output logic [1:0]       boost_rate_out,
	output logic [3:0]       boost_voltage_out,
	output logic [3:0]       boost_limit_out,
	output logic             launch_start,
	output logic             launch_down,
	output logic             bias_on_launch_pins,
	output logic signed [8:0] comp_threshold,
	output logic [15:0]      up_result_integer,
	output logic [15:0]      up_result_fraction,
	output logic [15:0]      dn_result_integer,
	output logic [15:0]      dn_result_fraction,
	output logic [15:0]      diff_result_integer,
	output logic [15:0]      diff_result_fraction,
	output logic [31:0]      diff_average,
	output logic [7:0]       ratio_t1_t2,
	output logic [7:0]       ratio_t2_ideal,
	output logic             flight_timeout_flag,
	output logic             measure_done_flag,
	output logic             int_n
);
	import flight_ctrl_pkg::*;

	// Asynchronous pins pass three flops; the first is read only by the second
	// Pin order in each stage: launch done, supply good, stop hit, comparator
	logic [2:0][3:0] sync_reg, sync_next;
	// Filtered levels move only when the second and third flops agree
	logic [3:0]      pin_lvl_reg, pin_lvl_next;
	logic comp_lvl, comp_prev_reg, comp_prev_next, hit_pulse, pg_lvl, ld_lvl;

	seq_state_e state_reg, state_next;
	logic [1:0]  cmd_reg, cmd_next;
	logic        down_reg, down_next;
	logic        pass2_reg, pass2_next;
	logic [23:0] wait_reg, wait_next;
	logic [23:0] tick_reg, tick_next;
	logic [5:0]  wave_reg, wave_next;
	logic [15:0] t1_reg, t1_next, t2_reg, t2_next;
	logic [31:0] up_time_reg, up_time_next;
	logic        up_fail_reg, up_fail_next;
	logic [31:0] avg_next, diff_val;
	logic [23:0] timeout_cyc;
	logic [15:0] quarter_int;

	// Copies of outputs kept as next-state terms
	logic busy_next, boost_next, launch_next, ldown_next, bias_next, to_next, done_next, intn_next;
	logic signed [8:0] thr_next;
	logic [15:0] ui_next, uf_next, di_next, df_next, xi_next, xf_next;
	logic [7:0] r12_next, r2i_next;
	logic [3:0] lim_next;

	assign comp_lvl = pin_lvl_reg[0];
	// Stop hit counts once, in the cycle where both late flops first agree high
	assign hit_pulse = sync_reg[2][1] && sync_reg[1][1] && !pin_lvl_reg[1];
	assign pg_lvl = pin_lvl_reg[2];
	assign ld_lvl = pin_lvl_reg[3];
	assign timeout_cyc = 24'(TIMEOUT_UNIT) << measure_timeout_select;
	assign diff_val = up_time_reg - {quarter_int, hit_fraction}; // [R03]
	assign quarter_int = (tick_reg[23:2] > 22'(INT_MAX)) ? INT_MAX : 16'(tick_reg[17:2]); // [R01]

	function automatic logic [7:0] ratio8(input logic [15:0] num, input logic [15:0] den);
		logic [31:0] q;
		q = 32'h0;
		if (den == 16'h0)
			q = 32'(RATIO_MAX);
		else
			q = ({16'h0, num} << 7) / {16'h0, den};
		ratio8 = (q > 32'(RATIO_MAX)) ? RATIO_MAX : q[7:0];
	endfunction

	always_comb begin
		sync_next = {sync_reg[1:0], launch_done, boost_power_good, stop_hit, comp_in};
		for (int i = 0; i < 4; i++) begin
			pin_lvl_next[i] = (sync_reg[2][i] == sync_reg[1][i]) ? sync_reg[2][i] : pin_lvl_reg[i];
		end
		comp_prev_next = comp_lvl;
		state_next = state_reg;
		cmd_next = cmd_reg;
		down_next = down_reg;
		pass2_next = pass2_reg;
		wait_next = wait_reg;
		tick_next = tick_reg + 24'h1;
		wave_next = wave_reg;
		t1_next = t1_reg;
		t2_next = t2_reg;
		up_time_next = up_time_reg;
		up_fail_next = up_fail_reg;
		busy_next = (state_reg != ST_IDLE);
		boost_next = boost_enable;
		launch_next = 1'b0;
		ldown_next = launch_down;
		bias_next = bias_on_launch_pins;
		thr_next = comp_threshold;
		ui_next = up_result_integer;
		uf_next = up_result_fraction;
		di_next = dn_result_integer;
		df_next = dn_result_fraction;
		xi_next = diff_result_integer;
		xf_next = diff_result_fraction;
		avg_next = diff_average;
		r12_next = ratio_t1_t2;
		r2i_next = ratio_t2_ideal;
		to_next = flight_timeout_flag;
		done_next = measure_done_flag;
		intn_next = int_n;
		lim_next = pg_lvl ? run_current_limit : startup_current_limit; // [R21]
		if (status_read) begin
			to_next = 1'b0;
			done_next = 1'b0;
		end
		case (state_reg)
		ST_IDLE: begin
			if (cmd_valid && cmd_code != 2'h0) begin
				cmd_next = cmd_code;
				down_next = (cmd_code == CMD_DN);
				pass2_next = 1'b0;
				up_fail_next = 1'b0;
				boost_next = 1'b1; // [R18]
				state_next = ST_BOOST;
			end
		end
		ST_BOOST: begin
			if (pg_lvl) begin
				wait_next = 24'(SETTLE_UNIT) * {20'h0, boost_settle_delay}; // [R22]
				state_next = ST_SETTLE;
			end
		end
		ST_SETTLE: begin
			if (wait_reg == 24'h0) begin
				launch_next = 1'b1;
				ldown_next = down_reg;
				bias_next = 1'b0;
				tick_next = 24'h0; // [R24]
				state_next = ST_LAUNCH;
			end else begin
				wait_next = wait_reg - 24'h1; // [R22]
			end
		end
		ST_LAUNCH: begin
			if (ld_lvl) begin
				boost_next = 1'b0; // [R18]
				bias_next = single_transducer_echo_enable; // [R04] [R05]
				// Threshold sign follows the trigger edge [R08] [R09] [R07]
				thr_next = down_reg ? 9'(downstream_first_threshold)
					: 9'(upstream_first_threshold);
				if (stop_falling)
					thr_next = -thr_next;
				wave_next = 6'h0;
				state_next = ST_FIRST;
			end
		end
		ST_FIRST: begin
			// The rising cycle is the first cycle of the width
			if (comp_lvl && !comp_prev_reg)
				t1_next = 16'h1;
			else if (comp_lvl)
				t1_next = t1_reg + 16'h1;
			if (!comp_lvl && comp_prev_reg) begin
				// Return threshold follows at once [R10] [R11]
				thr_next = down_reg ? 9'($signed(downstream_return_threshold))
					: 9'($signed(upstream_return_threshold));
				state_next = ST_SECOND;
			end
		end
		ST_SECOND: begin
			if (comp_lvl && !comp_prev_reg) begin
				wave_next = wave_reg + 6'h1;
				t2_next = 16'h1;
			end else if (comp_lvl)
				t2_next = t2_reg + 16'h1;
			if (!comp_lvl && comp_prev_reg && wave_reg == second_wave_index) begin // [R12]
				r12_next = ratio8(t1_reg, t2_reg); // [R13]
				r2i_next = ratio8(t2_reg, {8'h0, launch_half_period}); // [R13]
				state_next = ST_STOP;
			end
		end
		ST_STOP: begin
			if (hit_pulse) begin
				// Results land by direction, echo or not [R06] [R01] [R02]
				if (!down_reg) begin
					ui_next = quarter_int;
					uf_next = hit_fraction;
					up_time_next = {quarter_int, hit_fraction};
				end else begin
					di_next = quarter_int;
					df_next = hit_fraction;
					if (cmd_reg == CMD_DIFF && !up_fail_reg) begin
						xi_next = diff_val[31:16]; // [R03]
						xf_next = diff_val[15:0];
						avg_next = diff_average - (diff_average >>> 2) + (diff_val >>> 2);
					end else if (cmd_reg == CMD_DIFF) begin
						xi_next = DIFF_FAIL_INT; // [R15]
						xf_next = FAIL_WORD; // [R15] [R16]
					end
				end
				state_next = ST_DONE;
			end
		end
		ST_DONE: begin
			if (cmd_reg == CMD_DIFF && !pass2_reg) begin
				pass2_next = 1'b1;
				down_next = 1'b1;
				boost_next = 1'b1; // [R18]
				state_next = ST_BOOST;
			end else begin
				done_next = 1'b1;
				bias_next = 1'b0;
				state_next = ST_IDLE;
			end
		end
		default: state_next = ST_IDLE;
		endcase
		// Timeout fails the measurement; average left untouched unless a difference down hit lands in the same cycle [R14] [R15] [R16] [R17]
		if ((state_reg == ST_FIRST || state_reg == ST_SECOND || state_reg == ST_STOP)
			&& tick_reg >= timeout_cyc) begin
			to_next = 1'b1;
			r12_next = FAIL_WORD[7:0];
			r2i_next = FAIL_WORD[7:0];
			if (!down_reg) begin
				ui_next = FAIL_WORD;
				uf_next = FAIL_WORD;
				up_fail_next = 1'b1;
			end else begin
				di_next = FAIL_WORD;
				df_next = FAIL_WORD;
			end
			if (cmd_reg == CMD_DIFF && (down_reg || !pass2_reg)) begin
				xi_next = DIFF_FAIL_INT;
				xf_next = FAIL_WORD;
			end
			state_next = ST_DONE;
		end
		// Held low until status is read; a new event in that cycle wins [R17] [R23]
		intn_next = !(int_enable && (to_next || done_next));
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_reg <= 12'h000;
			pin_lvl_reg <= 4'h0;
			comp_prev_reg <= 1'b0;
			state_reg <= ST_IDLE;
			cmd_reg <= 2'h0;
			down_reg <= 1'b0;
			pass2_reg <= 1'b0;
			wait_reg <= 24'h0;
			tick_reg <= 24'h0;
			wave_reg <= 6'h0;
			t1_reg <= 16'h0;
			t2_reg <= 16'h0;
			up_time_reg <= 32'h0;
			up_fail_reg <= 1'b0;
			busy <= 1'b0;
			boost_enable <= 1'b0;
			boost_rate_out <= 2'h0;
			boost_voltage_out <= 4'h0;
			boost_limit_out <= 4'h0;
			launch_start <= 1'b0;
			launch_down <= 1'b0;
			bias_on_launch_pins <= 1'b0;
			comp_threshold <= 9'h0;
			up_result_integer <= 16'h0;
			up_result_fraction <= 16'h0;
			dn_result_integer <= 16'h0;
			dn_result_fraction <= 16'h0;
			diff_result_integer <= 16'h0;
			diff_result_fraction <= 16'h0;
			diff_average <= 32'h0;
			ratio_t1_t2 <= 8'h0;
			ratio_t2_ideal <= 8'h0;
			flight_timeout_flag <= 1'b0;
			measure_done_flag <= 1'b0;
			int_n <= 1'b1;
		end else begin
			sync_reg <= sync_next;
			pin_lvl_reg <= pin_lvl_next;
			comp_prev_reg <= comp_prev_next;
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			down_reg <= down_next;
			pass2_reg <= pass2_next;
			wait_reg <= wait_next;
			tick_reg <= tick_next;
			wave_reg <= wave_next;
			t1_reg <= t1_next;
			t2_reg <= t2_next;
			up_time_reg <= up_time_next;
			up_fail_reg <= up_fail_next;
			busy <= busy_next;
			boost_enable <= boost_next;
			boost_rate_out <= boost_switch_rate; // [R19]
			boost_voltage_out <= boost_voltage_select; // [R20]
			boost_limit_out <= lim_next;
			launch_start <= launch_next;
			launch_down <= ldown_next;
			bias_on_launch_pins <= bias_next;
			comp_threshold <= thr_next;
			up_result_integer <= ui_next;
			up_result_fraction <= uf_next;
			dn_result_integer <= di_next;
			dn_result_fraction <= df_next;
			diff_result_integer <= xi_next;
			diff_result_fraction <= xf_next;
			diff_average <= avg_next;
			ratio_t1_t2 <= r12_next;
			ratio_t2_ideal <= r2i_next;
			flight_timeout_flag <= to_next;
			measure_done_flag <= done_next;
			int_n <= intn_next;
		end
	end
endmodule

// file: core/flight_ctrl_pkg.sv
// Constants and types shared by the flight-time control block
package flight_ctrl_pkg;
	localparam int INT_W = 16;
	localparam int FRAC_W = 16;
	localparam logic [15:0] INT_MAX = 16'h7FFF;
	localparam logic [15:0] FRAC_MAX = 16'hFFFF;
	localparam logic [15:0] FAIL_WORD = 16'hFFFF;
	localparam logic [15:0] DIFF_FAIL_INT = 16'h7FFF;
	localparam logic [1:0] CMD_UP = 2'h1;
	localparam logic [1:0] CMD_DN = 2'h2;
	localparam logic [1:0] CMD_DIFF = 2'h3;
	localparam int CLK_HZ = 10_000_000;
	localparam int TOF_CLK_HZ = 4_000_000;
	localparam int SETTLE_UNIT_US = 128;
	localparam int SETTLE_UNIT_CYC = (SETTLE_UNIT_US * (CLK_HZ / 1_000_000));
	localparam int TIMEOUT_BASE_US = 128;
	localparam int TIMEOUT_BASE_CYC = (TIMEOUT_BASE_US * (CLK_HZ / 1_000_000));
	localparam logic [7:0] RATIO_ONE = 8'h80;
	localparam logic [7:0] RATIO_MAX = 8'hFF;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_BOOST  = 3'b001,
		ST_SETTLE = 3'b010,
		ST_LAUNCH = 3'b011,
		ST_FIRST  = 3'b100,
		ST_SECOND = 3'b101,
		ST_STOP   = 3'b110,
		ST_DONE   = 3'b111
	} seq_state_e;
endpackage

// file: testbench/far_side_model.sv
// Model of boost supply, launcher, transducer wave and hit detector
`timescale 1ns/1ps
module far_side_model (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic boost_enable,
	input  wire logic launch_start,
	input  wire logic launch_down,
	input  wire logic no_stop,
	output logic      boost_power_good,
	output logic      launch_done,
	output logic      comp_in,
	output logic      stop_hit,
	output logic [15:0] hit_fraction
);
	int pg_cnt;
	int t;
	int d;
	logic dn;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pg_cnt <= 0;
			t <= -1;
			dn <= 1'b0;
		end else begin
			pg_cnt <= boost_enable ? pg_cnt + 1 : 0;
			if (launch_start) begin
				t <= 0;
				dn <= launch_down;
			end else if (t >= 0 && t < 400)
				t <= t + 1;
		end
	end
	assign d = dn ? 80 : 120;
	// Slow ramp so the startup limit is seen for several cycles
	assign boost_power_good = boost_enable && pg_cnt >= 10;
	assign launch_done = t >= 6 && t < 10;
	// Waves of 4-cycle width every 8 cycles
	assign comp_in = t >= 12 && t < 140 && ((t - 12) % 8) < 4;
	assign stop_hit = !no_stop && t >= d && t < d + 4;
	// Outside the hit window the fraction lines show the inverse, never a stale value
	assign hit_fraction = (t >= d && t < d + 8) ? (dn ? 16'h1234 : 16'hABCD)
		: (dn ? 16'hEDCB : 16'h5432);
endmodule

// file: testbench/flight_ctrl_asserts.sv
// Port-level assertions for the flight-time control block
`timescale 1ns/1ps
module flight_ctrl_asserts #(
	parameter int TIMEOUT_UNIT = 4,
	parameter int SETTLE_UNIT  = 4
) (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic [1:0] boost_switch_rate,
	input wire logic [3:0] boost_voltage_select,
	input wire logic [3:0] startup_current_limit,
	input wire logic [3:0] run_current_limit,
	input wire logic [3:0] boost_settle_delay,
	input wire logic       int_enable,
	input wire logic       status_read,
	input wire logic       boost_power_good,
	input wire logic       launch_done,
	input wire logic       single_transducer_echo_enable,
	input wire logic       boost_enable,
	input wire logic [1:0] boost_rate_out,
	input wire logic [3:0] boost_voltage_out,
	input wire logic [3:0] boost_limit_out,
	input wire logic       launch_start,
	input wire logic       bias_on_launch_pins,
	input wire logic       flight_timeout_flag,
	input wire logic       measure_done_flag,
	input wire logic       int_n
);
	int good_reg;
	int good_next;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Raw supply-good time; the design sees it later, so its own count is never longer
	always_comb begin
		good_next = 0;
		if (boost_enable && boost_power_good)
			good_next = (good_reg < 1000) ? good_reg + 1 : good_reg;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			good_reg <= 0;
		else
			good_reg <= good_next;
	end
	property p_rate;
		boost_enable |-> boost_rate_out == boost_switch_rate;
	endproperty
	a_rate: assert property (p_rate) else $error("boost rate mismatch");
	property p_volt;
		boost_enable |-> boost_voltage_out == boost_voltage_select;
	endproperty
	a_volt: assert property (p_volt) else $error("boost voltage mismatch");
	// Three sync flops, the agreement filter and the output flop lag the pin by five edges
	property p_lim_start;
		(boost_enable && !boost_power_good)[*6] |-> boost_limit_out == startup_current_limit;
	endproperty
	a_lim_start: assert property (p_lim_start) else $error("startup limit wrong");
	property p_lim_run;
		(boost_enable && boost_power_good)[*6] |-> boost_limit_out == run_current_limit;
	endproperty
	a_lim_run: assert property (p_lim_run) else $error("run limit wrong");
	property p_boost_off;
		$rose(launch_done) |-> ##[1:6] !boost_enable;
	endproperty
	a_boost_off: assert property (p_boost_off) else $error("boost left on");
	property p_boost_on;
		launch_start |-> boost_enable;
	endproperty
	a_boost_on: assert property (p_boost_on) else $error("launch without boost");
	property p_settle;
		launch_start |-> good_reg >= SETTLE_UNIT * boost_settle_delay;
	endproperty
	a_settle: assert property (p_settle) else $error("launch before settle time");
	property p_int;
		(int_enable && (flight_timeout_flag || measure_done_flag))[*2] |-> !int_n;
	endproperty
	a_int: assert property (p_int) else $error("interrupt not asserted");
	property p_hold;
		(int_enable && !status_read)[*4] ##0 !int_n |=> !int_n || !int_enable;
	endproperty
	a_hold: assert property (p_hold) else $error("interrupt dropped early");
	property p_echo;
		bias_on_launch_pins |-> single_transducer_echo_enable;
	endproperty
	a_echo: assert property (p_echo) else $error("echo bias while disabled");
	c_launch: cover property (launch_start);
	c_timeout: cover property ($rose(flight_timeout_flag));
	c_done: cover property ($rose(measure_done_flag) && int_enable);
endmodule
bind flight_ctrl flight_ctrl_asserts #(
	.TIMEOUT_UNIT(TIMEOUT_UNIT),
	.SETTLE_UNIT(SETTLE_UNIT)
) u_asserts (.*);

// file: testbench/tb.sv
// Self-checking bench for the flight-time control block
`timescale 1ns/1ps
module tb;
	import flight_ctrl_pkg::*;
	typedef struct packed {
		logic [1:0] cmd;
		logic       echo;
		logic       fall;
		logic [7:0] half;
		logic [2:0] tsel;
		logic       ien;
		logic       nost;
	} row_s;
	localparam row_s ROWS [5] = '{
		'{CMD_UP, 1'b0, 1'b0, 8'h04, 3'h4, 1'b1, 1'b0},
		'{CMD_DN, 1'b1, 1'b1, 8'h08, 3'h4, 1'b0, 1'b0},
		'{CMD_DIFF, 1'b0, 1'b1, 8'h04, 3'h5, 1'b1, 1'b0},
		'{CMD_UP, 1'b0, 1'b0, 8'h04, 3'h0, 1'b1, 1'b1},
		'{CMD_DIFF, 1'b1, 1'b0, 8'h04, 3'h1, 1'b1, 1'b1}};
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic [1:0] cmd_code = 2'h0;
	logic single_transducer_echo_enable = 1'b0;
	logic stop_falling = 1'b0;
	logic [6:0] upstream_first_threshold = 7'h00;
	logic [6:0] downstream_first_threshold = 7'h00;
	logic [7:0] upstream_return_threshold = 8'h00;
	logic [7:0] downstream_return_threshold = 8'h00;
	logic [5:0] second_wave_index = 6'h01;
	logic [2:0] measure_timeout_select = 3'h4;
	logic [1:0] boost_switch_rate = 2'h0;
	logic [3:0] boost_voltage_select = 4'h0;
	logic [3:0] startup_current_limit = 4'h0;
	logic [3:0] run_current_limit = 4'h0;
	logic [3:0] boost_settle_delay = 4'h1;
	logic [7:0] launch_half_period = 8'h04;
	logic int_enable = 1'b0;
	logic status_read = 1'b0;
	logic no_stop = 1'b0;
	logic boost_power_good, launch_done, comp_in, stop_hit, busy, boost_enable;
	logic launch_start, launch_down, bias_on_launch_pins, int_n;
	logic flight_timeout_flag, measure_done_flag, saw_bias, saw_first, saw_ret, last_down;
	logic [1:0] boost_rate_out;
	logic [3:0] boost_voltage_out, boost_limit_out;
	logic signed [8:0] comp_threshold, e_first, e_ret;
	logic [15:0] hit_fraction, up_result_integer, up_result_fraction;
	logic [15:0] dn_result_integer, dn_result_fraction;
	logic [15:0] diff_result_integer, diff_result_fraction;
	logic [31:0] diff_average, avg0;
	logic [7:0] ratio_t1_t2, ratio_t2_ideal;
	int error_cnt = 0;
	int total_checks = 0;
	row_s r;
	flight_ctrl #(.TIMEOUT_UNIT(32), .SETTLE_UNIT(4)) dut (.*);
	far_side_model u_far (.*);
	always #50 clk = ~clk;
	always @(posedge clk) begin
		if (bias_on_launch_pins === 1'b1) saw_bias <= 1'b1;
		if (comp_threshold === e_first) saw_first <= 1'b1;
		if (comp_threshold === e_ret) saw_ret <= 1'b1;
		if (launch_start === 1'b1) last_down <= launch_down;
	end
	task automatic step;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rng(input string n, input logic [15:0] lo, input logic [15:0] g);
		total_checks++;
		if ((g >= lo && g <= lo + 16'h0002) !== 1'b1) begin
			error_cnt++;
			$display("wrong value %s expected %h to %h seen %h", n, lo, lo + 16'h0002, g);
		end
	endtask
	task automatic end_sim;
		if (error_cnt == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic start(input logic [1:0] c);
		cmd_valid = 1'b1;
		cmd_code = c;
		step;
		cmd_valid = 1'b0;
	endtask
	initial begin
		#3_000_000;
		error_cnt++;
		end_sim;
	end
	initial begin
		repeat (2) step;
		reset_n = 1'b1;
		chk("int_n", 16'h0001, {15'h0, int_n});
		chk("busy", 16'h0000, {15'h0, busy});
		for (int i = 0; i < 5; i++) begin
			r = ROWS[i];
			{single_transducer_echo_enable, stop_falling} = {r.echo, r.fall};
			{launch_half_period, measure_timeout_select} = {r.half, r.tsel};
			{int_enable, no_stop} = {r.ien, r.nost};
			boost_switch_rate = 2'(i);
			boost_voltage_select = 4'(3 * i + 1);
			startup_current_limit = 4'(i + 2);
			run_current_limit = 4'(12 - i);
			boost_settle_delay = 4'(i + 1);
			upstream_first_threshold = 7'(8 * i + 5);
			downstream_first_threshold = 7'(127 - i);
			upstream_return_threshold = 8'(128 + i);
			downstream_return_threshold = 8'(127 - i);
			second_wave_index = 6'(i + 1);
			e_first = (r.cmd == CMD_UP) ? {2'b00, upstream_first_threshold}
				: {2'b00, downstream_first_threshold};
			e_first = r.fall ? -e_first : e_first;
			e_ret = (r.cmd == CMD_UP) ? {upstream_return_threshold[7], upstream_return_threshold}
				: {downstream_return_threshold[7], downstream_return_threshold};
			{saw_bias, saw_first, saw_ret} = 3'b000;
			avg0 = diff_average;
			start(r.cmd);
			for (int n = 0; n < 3000 && !(measure_done_flag | flight_timeout_flag); n++) step;
			repeat (3) step;
			chk("int_n", {15'h0, ~r.ien}, {15'h0, int_n});
			chk("timeout flag", {15'h0, r.nost}, {15'h0, flight_timeout_flag});
			if (r.nost) begin
				chk("up int", FAIL_WORD, up_result_integer);
				chk("up frac", FAIL_WORD, up_result_fraction);
				chk("ratio", 16'h00FF, {8'h00, ratio_t1_t2});
				chk("ratio2", 16'h00FF, {8'h00, ratio_t2_ideal});
				if (r.cmd == CMD_DIFF) begin
					chk("diff int", DIFF_FAIL_INT, diff_result_integer);
					chk("diff frac", FAIL_WORD, diff_result_fraction);
					chk("avg hi", avg0[31:16], diff_average[31:16]);
					chk("avg lo", avg0[15:0], diff_average[15:0]);
				end
			end else begin
				chk("bias", {15'h0, r.echo}, {15'h0, saw_bias});
				chk("launch dir", {15'h0, r.cmd != CMD_UP}, {15'h0, last_down});
				chk("first thr", 16'h0001, {15'h0, saw_first});
				chk("return thr", 16'h0001, {15'h0, saw_ret});
				chk("t1 t2", 16'h0080, {8'h00, ratio_t1_t2});
				// Four-cycle waves against an ideal of half clock cycles, 80h is one
				chk("t2 ideal", 16'd512 / r.half, {8'h00, ratio_t2_ideal});
				if (r.cmd != CMD_DN) begin
					rng("up int", 16'd30, up_result_integer);
					chk("up frac", 16'hABCD, up_result_fraction);
				end
				if (r.cmd != CMD_UP) begin
					rng("dn int", 16'd20, dn_result_integer);
					chk("dn frac", 16'h1234, dn_result_fraction);
				end
				if (r.cmd == CMD_DIFF) begin
					chk("diff int", up_result_integer - dn_result_integer, diff_result_integer);
					chk("diff frac", 16'h9999, diff_result_fraction);
				end
			end
			status_read = 1'b1;
			step;
			status_read = 1'b0;
			repeat (3) step;
			chk("int_n clear", 16'h0001, {15'h0, int_n});
			for (int n = 0; n < 3000 && busy !== 1'b0; n++) step;
		end
		// Reset in mid-run must drop busy, boost and the up result at once
		start(CMD_UP);
		repeat (30) step;
		reset_n = 1'b0;
		step;
		chk("busy", 16'h0000, {15'h0, busy});
		chk("boost", 16'h0000, {15'h0, boost_enable});
		chk("up int reset", 16'h0000, up_result_integer);
		reset_n = 1'b1;
		repeat (2) step;
		chk("int_n", 16'h0001, {15'h0, int_n});
		chk("busy", 16'h0000, {15'h0, busy});
		// A command right after release must run as from power-up
		{measure_timeout_select, no_stop} = {3'h4, 1'b0};
		start(CMD_UP);
		for (int n = 0; n < 3000 && measure_done_flag !== 1'b1; n++) step;
		chk("up frac", 16'hABCD, up_result_fraction);
		rng("up int", 16'd30, up_result_integer);
		end_sim;
	end
endmodule
